// File: logic/pin_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser, one stage pair per bit
module pin_sync #(
  parameter W = 4
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_r;  // First stage, read only by second
      reg sync_r;  // Second stage
      // Pins idle high (inactive), so reset to one
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r <= 1'b1;
          sync_r <= 1'b1;
        end else begin
          meta_r <= d[i];
          sync_r <= meta_r;
        end
      end
      assign q[i] = sync_r;
    end
  endgenerate
endmodule // pin_sync

// File: logic/uart_modem_status_interrupts.v
// Functional notes
// - Status bit7: not carrier pin, loop: control3
// - Status bit6: not ring pin, loop: control2
// - Status bit5: not dsr pin, loop: control0
// - Status bit4: not cts pin, loop: control1
// - Bit3 flags carrier change; read clears
// - Bit2 flags ring rising edge; read clears
// - Bit1 flags dsr change; read clears
// - Bit0 flags cts change; read clears
// - Enable bits 7,6,5: cts, rts, xoff
// - Enable bits 3..0: modem, line, thr, rhr
// - Enable bit4 selects sleep mode
// - Enable bits 7:4 writable only with wren
// - Re-enabling thr raises no new interrupt
// - Interrupt output follows enabled pending sources
// - Source register read-only, highest priority shown
// - Source bit0 low while anything pending
// - Source bits 7:6 mirror fifo enable
// - Line error code 000110, top priority
// - Timeout 001100, rhr 000100, thr 000010
// - Modem 000000, xoff/special 010000
// - Rts/cts inactive change 100000, lowest
// - Control bit4 selects internal loop-back
// - Special char match sets source bit4
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "uart_msi_regs.vh"
module uart_modem_status_interrupts (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        cd_n,
  input  wire        ri_n,
  input  wire        dsr_n,
  input  wire        cts_n,
  input  wire        line_err,
  input  wire        rx_timeout,
  input  wire        rx_ready,
  input  wire        tx_space_evt,
  input  wire        thr_write,
  input  wire        xoff_evt,
  input  wire        char_match_evt,
  input  wire        rts_inactive_evt,
  output wire        irq,
  output wire        dtr_n,
  output wire        rts_n,
  output wire        op_n,
  output wire        loopback,
  output wire        sleep_en
);

  // Synchronised pins {cd, ri, dsr, cts}
  wire [3:0] pin_s;

  // Register state
  reg  [7:0]  hs_control_r;   // Handshake control
  reg  [7:0]  int_enable_r;   // Interrupt enable
  reg  [7:0]  enh_ctrl_r;     // Enhanced feature control
  reg  [7:0]  queue_ctrl_r;   // Queue control
  reg  [3:0]  line_r;         // Current {cd, ri, dsr, cts}
  reg  [3:0]  delta_r;        // Change flags
  reg         thr_pend_r;     // Transmit space pending
  reg         xoff_pend_r;    // Xoff/special pending
  reg         rtscts_pend_r;  // Rts/cts inactive pending
  reg         irq_r;          // Interrupt output flop
  reg  [31:0] prdata_r;       // Read data
  reg         pready_r;       // Access completes
  reg         pslverr_r;      // Unmapped address
  reg         dtr_n_r;        // Pin flops
  reg         rts_n_r;
  reg         op_n_r;

  // Next values
  reg  [3:0]  line_nxt;
  reg  [3:0]  delta_nxt;
  reg  [7:0]  hs_control_nxt;
  reg  [7:0]  int_enable_nxt;
  reg         thr_pend_nxt;
  reg         xoff_pend_nxt;
  reg         rtscts_pend_nxt;
  reg  [5:0]  id_code;        // Bits 5:0 of source register
  reg  [7:0]  rd_mux;         // Read data selection
  reg         rd_hit;         // Address decodes

  // Bus phase decode
  wire access  = psel & penable;
  wire done    = access & pready_r;
  wire wr_done = done & pwrite;
  wire rd_done = done & ~pwrite;
  wire wr_hs   = wr_done & (paddr == `OFS_HS_CONTROL);
  wire wr_ie   = wr_done & (paddr == `OFS_INT_ENABLE);
  wire wr_ef   = wr_done & (paddr == `OFS_ENH_CTRL);
  wire wr_qc   = wr_done & (paddr == `OFS_QUEUE_CTRL);
  wire rd_stat = rd_done & (paddr == `OFS_HS_STATUS);
  wire rd_src  = rd_done & (paddr == `OFS_INT_SOURCE);
  wire loop_on = hs_control_r[`HC_LOOP];
  wire wren    = enh_ctrl_r[`EF_WREN];

  // Pin synchroniser
  pin_sync #(
    .W (4)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({cd_n, ri_n, dsr_n, cts_n}),
    .q       (pin_s)
  );

  // Line source: inverted pins, or control bits in loop-back
  always @* begin
    if (loop_on) begin
      line_nxt = {hs_control_r[`HC_OP], hs_control_r[`HC_OUT2],
                  hs_control_r[`HC_DTR], hs_control_r[`HC_RTS]};
    end else begin
      line_nxt = ~pin_s;
    end
  end

  // Ring source rising: pin going high (status falling), or control bit2 rising in loop-back
  wire ri_rise = loop_on ? (line_nxt[2] & ~line_r[2]) : (line_r[2] & ~line_nxt[2]);

  // Change flags; a read clears only what it returned, so a late event is not lost
  always @* begin
    delta_nxt = rd_stat ? (delta_r & ~prdata_r[3:0]) : delta_r;
    if (line_nxt[3] != line_r[3]) begin
      delta_nxt[3] = 1'b1;
    end
    if (ri_rise) begin
      delta_nxt[2] = 1'b1;
    end
    if (line_nxt[1] != line_r[1]) begin
      delta_nxt[1] = 1'b1;
    end
    if (line_nxt[0] != line_r[0]) begin
      delta_nxt[0] = 1'b1;
    end
  end

  // Enabled conditions
  wire line_act  = int_enable_r[`IE_LINE] & line_err;
  wire tmo_act   = int_enable_r[`IE_RHR] & rx_timeout;
  wire rhr_act   = int_enable_r[`IE_RHR] & rx_ready;
  wire thr_act   = int_enable_r[`IE_THR] & thr_pend_r;
  wire modem_act = int_enable_r[`IE_MODEM] & (|delta_r);
  wire xoff_act  = int_enable_r[`IE_XOFF] & xoff_pend_r;
  wire rc_act    = (int_enable_r[`IE_CTS] | int_enable_r[`IE_RTS]) & rtscts_pend_r;

  // Priority encoder, highest priority first
  always @* begin
    if (line_act) begin
      id_code = `ID_LINE;
    end else if (tmo_act) begin
      id_code = `ID_TIMEOUT;
    end else if (rhr_act) begin
      id_code = `ID_RHR;
    end else if (thr_act) begin
      id_code = `ID_THR;
    end else if (modem_act) begin
      id_code = `ID_MODEM;
    end else if (xoff_act) begin
      id_code = `ID_XOFF;
    end else if (rc_act) begin
      id_code = `ID_RTSCTS;
    end else begin
      id_code = `ID_NONE;
    end
  end

  // Source register value with fifo enable mirror
  wire [7:0] src_val = {{2{queue_ctrl_r[`QC_FIFO_EN]}}, id_code};

  // Transmit space pending: set only by an event while enabled
  always @* begin
    thr_pend_nxt = thr_pend_r;
    if (thr_write | (rd_src & (prdata_r[5:0] == `ID_THR))) begin
      thr_pend_nxt = 1'b0;
    end
    if (~int_enable_r[`IE_THR]) begin
      thr_pend_nxt = 1'b0;
    end
    if (tx_space_evt & int_enable_r[`IE_THR]) begin
      thr_pend_nxt = 1'b1;
    end
  end

  // Xoff and special character pending
  always @* begin
    xoff_pend_nxt = xoff_pend_r;
    if (rd_src & (prdata_r[5:0] == `ID_XOFF)) begin
      xoff_pend_nxt = 1'b0;
    end
    if (xoff_evt | (char_match_evt & enh_ctrl_r[`EF_SPECIAL])) begin
      xoff_pend_nxt = 1'b1;
    end
  end

  // Rts/cts inactive transition pending
  always @* begin
    rtscts_pend_nxt = rtscts_pend_r;
    if (rd_src & (prdata_r[5:0] == `ID_RTSCTS)) begin
      rtscts_pend_nxt = 1'b0;
    end
    if ((int_enable_r[`IE_CTS] & line_r[0] & ~line_nxt[0]) |
        (int_enable_r[`IE_RTS] & rts_inactive_evt)) begin
      rtscts_pend_nxt = 1'b1;
    end
  end

  // Control writes; upper bits guarded by write enable
  always @* begin
    hs_control_nxt = hs_control_r;
    int_enable_nxt = int_enable_r;
    if (wr_hs) begin
      hs_control_nxt[4:0] = pwdata[4:0];
      if (wren) begin
        hs_control_nxt[7:5] = pwdata[7:5];
      end
    end
    if (wr_ie) begin
      int_enable_nxt[3:0] = pwdata[3:0];
      if (wren) begin
        int_enable_nxt[7:4] = pwdata[7:4];
      end
    end
  end

  // Read mux and address decode
  always @* begin
    rd_hit = 1'b1;
    case (paddr)
      `OFS_HS_STATUS: begin
        rd_mux = {line_r, delta_r};
      end
      `OFS_INT_ENABLE: begin
        rd_mux = int_enable_r;
      end
      `OFS_INT_SOURCE: begin
        rd_mux = src_val;
      end
      `OFS_HS_CONTROL: begin
        rd_mux = hs_control_r;
      end
      `OFS_ENH_CTRL: begin
        rd_mux = enh_ctrl_r;
      end
      `OFS_QUEUE_CTRL: begin
        rd_mux = queue_ctrl_r;
      end
      default: begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Register and status state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_control_r  <= `RST_HS_CONTROL;
      int_enable_r  <= `RST_INT_ENABLE;
      enh_ctrl_r    <= `RST_ENH_CTRL;
      queue_ctrl_r  <= `RST_QUEUE_CTRL;
      line_r        <= 4'h0;
      delta_r       <= 4'h0;
      thr_pend_r    <= 1'b0;
      xoff_pend_r   <= 1'b0;
      rtscts_pend_r <= 1'b0;
    end else begin
      hs_control_r  <= hs_control_nxt;
      int_enable_r  <= int_enable_nxt;
      line_r        <= line_nxt;
      delta_r       <= delta_nxt;
      thr_pend_r    <= thr_pend_nxt;
      xoff_pend_r   <= xoff_pend_nxt;
      rtscts_pend_r <= rtscts_pend_nxt;
      if (wr_ef) begin
        enh_ctrl_r <= pwdata[7:0];
      end
      if (wr_qc) begin
        queue_ctrl_r <= pwdata[7:0];
      end
    end
  end

  // Interrupt output, one cycle behind the pending state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ~id_code[0];
    end
  end

  // Handshake output pins; held inactive in loop-back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtr_n_r <= 1'b1;
      rts_n_r <= 1'b1;
      op_n_r  <= 1'b1;
    end else begin
      dtr_n_r <= loop_on | ~hs_control_r[`HC_DTR];
      rts_n_r <= loop_on | ~hs_control_r[`HC_RTS];
      op_n_r  <= loop_on | ~hs_control_r[`HC_OP];
    end
  end

  // APB slave: one wait state, data captured in first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r <= access & ~pready_r;
      if (access & ~pready_r) begin
        pslverr_r <= ~rd_hit;
        prdata_r  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
      end else begin
        pslverr_r <= 1'b0;
        prdata_r  <= 32'h0000_0000;
      end
    end
  end

  // Outputs straight from flops
  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign irq      = irq_r;
  assign dtr_n    = dtr_n_r;
  assign rts_n    = rts_n_r;
  assign op_n     = op_n_r;
  assign loopback = hs_control_r[`HC_LOOP];
  assign sleep_en = int_enable_r[`IE_SLEEP];

endmodule // uart_modem_status_interrupts

// File: logic/uart_msi_regs.vh
`ifndef UART_MSI_REGS_VH
`define UART_MSI_REGS_VH
// Register byte offsets
`define OFS_HS_STATUS   8'h00
`define OFS_INT_ENABLE  8'h04
`define OFS_INT_SOURCE  8'h08
`define OFS_HS_CONTROL  8'h0C
`define OFS_ENH_CTRL    8'h10
`define OFS_QUEUE_CTRL  8'h14
// Reset values
`define RST_HS_CONTROL  8'h00
`define RST_INT_ENABLE  8'h00
`define RST_ENH_CTRL    8'h00
`define RST_QUEUE_CTRL  8'h00
// Interrupt enable fields
`define IE_CTS          7
`define IE_RTS          6
`define IE_XOFF         5
`define IE_SLEEP        4
`define IE_MODEM        3
`define IE_LINE         2
`define IE_THR          1
`define IE_RHR          0
// Handshake control fields
`define HC_LOOP         4
`define HC_OP           3
`define HC_OUT2         2
`define HC_RTS          1
`define HC_DTR          0
// Enhanced feature fields
`define EF_SPECIAL      5
`define EF_WREN         4
// Queue control fields
`define QC_FIFO_EN      0
// Interrupt source codes, bits 5:0
`define ID_NONE         6'h01
`define ID_LINE         6'h06
`define ID_TIMEOUT      6'h0C
`define ID_RHR          6'h04
`define ID_THR          6'h02
`define ID_MODEM        6'h00
`define ID_XOFF         6'h10
`define ID_RTSCTS       6'h20
`endif

// File: test/modem_partner.sv
`timescale 1ns/1ps
// Modem side: moves its pins on the clock as asked
module modem_partner (
  input  wire       pclk,
  input  wire [3:0] want,
  output reg  [3:0] pins
);
  // Pins idle inactive (high)
  initial pins = 4'hF;
  always @(posedge pclk) begin
    pins <= want;
  end
endmodule // modem_partner

// File: test/uart_modem_status_interrupts_test.sv
`timescale 1ns/1ps
module uart_modem_status_interrupts_test;
  reg         pclk = 0;         // Bus clock
  reg         presetn = 0;      // Reset
  reg         psel = 0, penable = 0, pwrite = 0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg  [2:0]  lv = 3'h0;        // Line error, timeout, rx ready
  reg  [4:0]  ev = 5'h0;        // Tx space, thr write, xoff, match, rts
  reg  [3:0]  want = 4'hF;      // Requested modem pins
  wire [3:0]  pins;             // cd, ri, dsr, cts
  wire [31:0] prdata;
  wire        pready, pslverr, irq, dtr_n, rts_n, op_n, loopback, sleep_en;
  reg  [31:0] rnd = 32'h198CCBFC, q;
  reg  [3:0]  p = 4'hF, n;
  reg         se;
  int         mismatches = 0, checked = 0, cyc = 0, i;
  always #2.5 pclk = ~pclk;
  uart_modem_status_interrupts u_uart_modem_status_interrupts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cd_n(pins[3]), .ri_n(pins[2]), .dsr_n(pins[1]), .cts_n(pins[0]),
    .line_err(lv[2]), .rx_timeout(lv[1]), .rx_ready(lv[0]), .tx_space_evt(ev[4]),
    .thr_write(ev[3]), .xoff_evt(ev[2]), .char_match_evt(ev[1]), .rts_inactive_evt(ev[0]),
    .irq(irq), .dtr_n(dtr_n), .rts_n(rts_n), .op_n(op_n), .loopback(loopback), .sleep_en(sleep_en));
  modem_partner u_modem_partner (.pclk(pclk), .want(want), .pins(pins));
  // Next pseudo-random word
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task conclude;
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input [31:0] s, input [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer, held until pready
  task bus(input w, input [7:0] a, input [31:0] d, output [31:0] r);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1, a, d, q);
  endtask
  task rd(input [7:0] a, input [31:0] e, input string nm);
    bus(0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task pulse(input int b);
    ev[b] <= 1;
    @(posedge pclk);
    ev <= 5'h0;
  endtask
  // Settle, then check irq and the reported source
  task src(input [7:0] c);
    repeat (3) @(posedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, ~c[0]});
    rd(8'h08, {24'h0, c}, "source");
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      conclude;
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    rd(8'h04, 32'h0, "enable");
    rd(8'h00, 32'h0, "status");
    src(8'h01);
    chk("sleep", {31'h0, sleep_en}, 32'h0);
    rd(8'h40, 32'h0, "unmapped");
    chk("slverr", {31'h0, se}, 32'h1);
    wr(8'h08, 32'hFF);
    rd(8'h08, 32'h01, "source ro");
    wr(8'h04, 32'hFF);
    rd(8'h04, 32'h0F, "protected");
    wr(8'h10, 32'h30);
    wr(8'h04, 32'hFF);
    rd(8'h04, 32'hFF, "enable");
    chk("sleep", {31'h0, sleep_en}, 32'h1);
    wr(8'h04, 32'h0);
    // Random modem pin moves, flags then read-clear
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      n = rnd[3:0];
      want <= n;
      repeat (6) @(posedge pclk);
      rd(8'h00, {24'h0, ~n, p[3] ^ n[3], ~p[2] & n[2], p[1] ^ n[1], p[0] ^ n[0]}, "status");
      rd(8'h00, {24'h0, ~n, 4'h0}, "cleared");
      p = n;
    end
    // Loop-back routes control bits to status
    rnd = lfsr(rnd);
    wr(8'h0C, {27'h0, 1'b1, rnd[3:0]});
    repeat (6) @(posedge pclk);
    bus(0, 8'h00, 32'h0, q);
    chk("loop", {28'h0, q[7:4]}, {28'h0, rnd[3], rnd[2], rnd[0], rnd[1]});
    chk("pins", {loopback, dtr_n, rts_n, op_n}, 32'hF);
    wr(8'h0C, 32'h0B);
    repeat (3) @(posedge pclk);
    chk("pins", {loopback, dtr_n, rts_n, op_n}, 32'h0);
    wr(8'h0C, 32'h0);
    repeat (6) @(posedge pclk);
    chk("pins", {loopback, dtr_n, rts_n, op_n}, 32'h7);
    bus(0, 8'h00, 32'h0, q);
    bus(0, 8'h00, 32'h0, q);
    // Priority ordering with fifo enabled
    wr(8'h14, 32'h01);
    wr(8'h04, 32'h6F);
    lv <= 3'h7;
    src(8'hC6);
    lv <= 3'h3;
    src(8'hCC);
    lv <= 3'h1;
    src(8'hC4);
    lv <= 3'h0;
    pulse(4);
    src(8'hC2);
    pulse(3);
    src(8'hC1);
    wr(8'h04, 32'h6D);
    wr(8'h04, 32'h6F);
    src(8'hC1);
    pulse(2);
    src(8'hD0);
    src(8'hC1);
    pulse(1);
    src(8'hD0);
    src(8'hC1);
    pulse(0);
    src(8'hE0);
    src(8'hC1);
    n = ~p;
    want <= n;
    repeat (4) @(posedge pclk);
    src(8'hC0);
    rd(8'h00, {24'h0, ~n, 1'b1, ~p[2] & n[2], 2'h3}, "status");
    src(8'hC1);
    conclude;
  end
endmodule // uart_modem_status_interrupts_test

// File: test/uart_msi_checker.sv
`timescale 1ns/1ps
// Port-level protocol and output checks
module uart_msi_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        irq,
  input wire        dtr_n,
  input wire        rts_n,
  input wire        op_n,
  input wire        loopback
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_src = pready && !pwrite && paddr == 8'h08;
  ready_once_a: assert property (pready |=> !pready)
    else $error("pready held");
  wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("wait state wrong");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  unmapped_err_a: assert property (pready && paddr > 8'h14 |-> pslverr)
    else $error("unmapped accepted");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  source_mirror_a: assert property (rd_src |-> prdata[7] == prdata[6])
    else $error("mirror bits differ");
  source_idle_a: assert property (rd_src && !irq && !$past(irq) && !$past(irq, 2) |-> prdata[0])
    else $error("idle code wrong");
  loop_outs_a: assert property (loopback && $past(loopback) |-> dtr_n && rts_n && op_n)
    else $error("outputs in loop");
endmodule // uart_msi_checker
bind uart_modem_status_interrupts uart_msi_checker u_uart_msi_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .dtr_n(dtr_n), .rts_n(rts_n), .op_n(op_n), .loopback(loopback));
